// ===== fsdp_pkg.sv
`default_nettype none
package fsdp_pkg;
   // Special function register addresses
   localparam logic [7:0] FSDP_ADDR_FCTL  = 8'hd5;
   localparam logic [7:0] FSDP_ADDR_DPORT = 8'hd6;
   localparam logic [7:0] FSDP_ADDR_WDC   = 8'hd8;
   // Flash commands
   localparam logic [3:0] FSDP_CMD_READ     = 4'h0;
   localparam logic [3:0] FSDP_CMD_VER_OPT  = 4'h1;
   localparam logic [3:0] FSDP_CMD_VER_SEC  = 4'h2;
   localparam logic [3:0] FSDP_CMD_VER_UPR  = 4'h3;
   localparam logic [3:0] FSDP_CMD_WR_OPT   = 4'h9;
   localparam logic [3:0] FSDP_CMD_WR_SEC   = 4'ha;
   localparam logic [3:0] FSDP_CMD_WR_UPR   = 4'hb;
   localparam logic [3:0] FSDP_CMD_ER_OPT   = 4'hc;
   localparam logic [3:0] FSDP_CMD_ER_SEC   = 4'hd;
   localparam logic [3:0] FSDP_CMD_ER_UPR   = 4'he;
   // Security block
   localparam logic [7:0] FSDP_LOCK_ADDR    = 8'h40;
   localparam int         FSDP_LOCK_HI_POS  = 5;
   localparam int         FSDP_LOCK_MID_POS = 4;
   localparam int         FSDP_LOCK_LO_POS  = 3;
   localparam int         FSDP_OPT_WDR_POS  = 3;
   localparam int         FSDP_SEC_DEPTH    = 65;
   // Upper bank window
   localparam logic [15:0] FSDP_UPR_LO = 16'h2000;
   localparam logic [15:0] FSDP_UPR_HI = 16'h3fff;
   localparam int          FSDP_UPR_DEPTH = 8192;
   // Reset and erase values
   localparam logic [7:0] FSDP_DPORT_RST = 8'h00;
   localparam logic [7:0] FSDP_ERASED    = 8'hff;
   // Watchdog control bit positions
   localparam int FSDP_WD_BAUD = 7;
   localparam int FSDP_WD_POR  = 6;
   localparam int FSDP_WD_PFE  = 5;
   localparam int FSDP_WD_PFF  = 4;
   localparam int FSDP_WD_WIF  = 3;
   localparam int FSDP_WD_WRF  = 2;
   localparam int FSDP_WD_EN   = 1;
   localparam int FSDP_WD_RST  = 0;
   // Busy time of a flash program or erase
   localparam int FSDP_PROG_NS     = 400;
   localparam int FSDP_CLK_NS      = 10;
   localparam int FSDP_PROG_CYCLES = (FSDP_PROG_NS + FSDP_CLK_NS - 1) / FSDP_CLK_NS;
   // Protection levels
   typedef enum logic [1:0] {FSDP_LVL1, FSDP_LVL2, FSDP_LVL3, FSDP_LVL4} fsdp_level_e;
endpackage
`default_nettype wire

// ===== fsdp_lock_decode.sv
`timescale 1ns/1ps
`default_nettype none
module fsdp_lock_decode (
   // Lock bits, 1 = erased
   input  wire logic              i_lock_bit_high,
   input  wire logic              i_lock_bit_mid,
   input  wire logic              i_lock_bit_low,
   // Decoded level and gates
   output fsdp_pkg::fsdp_level_e  o_level,
   output logic                   o_block_ext_code_read,
   output logic                   o_block_program,
   output logic                   o_block_verify,
   output logic                   o_block_ext_data,
   output logic                   o_block_ext_exec
);
   // Strongest level any programmed bit implies, so odd mixes never weaken
   assign o_level = !i_lock_bit_high ? fsdp_pkg::FSDP_LVL4 :
                    !i_lock_bit_mid  ? fsdp_pkg::FSDP_LVL3 :
                    !i_lock_bit_low  ? fsdp_pkg::FSDP_LVL2 :
                                       fsdp_pkg::FSDP_LVL1;
   // Each gate holds from its level upward
   assign o_block_ext_code_read = (o_level != fsdp_pkg::FSDP_LVL1);
   assign o_block_program       = (o_level != fsdp_pkg::FSDP_LVL1);
   assign o_block_verify        = (o_level == fsdp_pkg::FSDP_LVL3) ||
                                  (o_level == fsdp_pkg::FSDP_LVL4);
   assign o_block_ext_data      = o_block_verify;
   assign o_block_ext_exec      = (o_level == fsdp_pkg::FSDP_LVL4);
endmodule
`default_nettype wire

// ===== fsdp_flash_security_data_port.sv
// Behaviour
// - Option word bits other than bit 3 are plain nonvolatile user storage.
// - Power-on reset sets watchdog reset enable when option bit 3 is zero.
// - Lock bits live at security byte 40h, bits 5,4,3 high first.
// - Lock bit reads 1 erased, 0 programmed; all ones means no protection.
// - Level 2 blocks external code-table reads of internal program memory.
// - Level 2 and above refuse flash programming by parallel port and loader.
// - Level 3 and above block verify and external-code internal data access.
// - Level 4 also blocks execution from external program memory.
// - Data port is 8-bit register at D6h, reset zero, carries address and data.
// - Watchdog control at D8h; protected bits need timed access; reset values.
// - Command 1011 takes address high, address low, data; programs 2000h-3FFFh.
// - Error flag sets on failure or invalid command; clears on command 0000b.
// - Command 0010 with address write returns that security byte.
// - Busy flag low during program or erase, high when done or on error; option-word programs here leave it high.
`timescale 1ns/1ps
`default_nettype none
module fsdp_flash_security_data_port (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_power_on,
   // Special function register bus
   input  wire logic [7:0]  i_sfr_addr,
   input  wire logic        i_sfr_wr,
   input  wire logic [7:0]  i_sfr_wdata,
   input  wire logic        i_timed_access,
   output logic      [7:0]  o_sfr_rdata,
   // Protection gates
   output logic             o_block_ext_code_read,
   output logic             o_block_program,
   output logic             o_block_verify,
   output logic             o_block_ext_data,
   output logic             o_block_ext_exec,
   // Watchdog controls
   output logic             o_watchdog_reset_enable,
   output logic             o_baud_doubling
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum {FSDP_IDLE, FSDP_ADDR_LO, FSDP_DATA, FSDP_BUSY} fsdp_state_e;

   logic [7:0]  dport_r, dport_nxt;
   logic [3:0]  cmd_r;
   logic        err_r;
   logic        busy_r;
   logic [8:0]  busy_cnt_r;
   logic [7:0]  addr_hi_r;
   logic [7:0]  addr_lo_r;
   logic [7:0]  opt_r;
   logic [7:0]  wdc_r;
   logic [7:0]  sec_mem [0:fsdp_pkg::FSDP_SEC_DEPTH-1];
   logic [7:0]  upr_mem [0:fsdp_pkg::FSDP_UPR_DEPTH-1];
   fsdp_state_e st_r;

   ////////////////////////////////////////////////////////////////////////
   // Lock bits come straight from the security byte at 40h
   wire [7:0] lock_byte = sec_mem[fsdp_pkg::FSDP_LOCK_ADDR[6:0]];
   fsdp_lock_decode u_lock (
      .i_lock_bit_high       (lock_byte[fsdp_pkg::FSDP_LOCK_HI_POS]),
      .i_lock_bit_mid        (lock_byte[fsdp_pkg::FSDP_LOCK_MID_POS]),
      .i_lock_bit_low        (lock_byte[fsdp_pkg::FSDP_LOCK_LO_POS]),
      .o_level               (),
      .o_block_ext_code_read (o_block_ext_code_read),
      .o_block_program       (o_block_program),
      .o_block_verify        (o_block_verify),
      .o_block_ext_data      (o_block_ext_data),
      .o_block_ext_exec      (o_block_ext_exec)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decode of bus writes and command validity
   wire wr_fctl  = i_sfr_wr && (i_sfr_addr == fsdp_pkg::FSDP_ADDR_FCTL) && i_timed_access;
   wire wr_dport = i_sfr_wr && (i_sfr_addr == fsdp_pkg::FSDP_ADDR_DPORT);
   wire wr_wdc   = i_sfr_wr && (i_sfr_addr == fsdp_pkg::FSDP_ADDR_WDC);
   wire cmd_ok   = (cmd_r != fsdp_pkg::FSDP_CMD_READ) &&
                   ((cmd_r <= 4'h4) || (cmd_r >= 4'h8));
   wire new_bad  = wr_fctl && (i_sfr_wdata[3:0] >= 4'h5) && (i_sfr_wdata[3:0] <= 4'h7);
   wire take     = wr_dport && cmd_ok && busy_r && (st_r != FSDP_BUSY);
   wire [15:0] addr16 = {addr_hi_r, addr_lo_r};
   wire upr_ok   = (addr16 >= fsdp_pkg::FSDP_UPR_LO) && (addr16 <= fsdp_pkg::FSDP_UPR_HI);
   wire sec_ok   = (addr_lo_r <= fsdp_pkg::FSDP_LOCK_ADDR);
   // A security or upper-bank program attempt that protection or address range refuses is a failure
   wire prog_fail = take && (st_r == FSDP_DATA) &&
                    (o_block_program || ((cmd_r == fsdp_pkg::FSDP_CMD_WR_UPR) ? !upr_ok :
                                         (cmd_r == fsdp_pkg::FSDP_CMD_WR_SEC) ? !sec_ok : 1'b0));
   wire prog_go  = take && (st_r == FSDP_DATA) && !prog_fail;
   wire is_erase = (i_sfr_wdata[3:0] >= fsdp_pkg::FSDP_CMD_ER_OPT) &&
                   (i_sfr_wdata[3:0] <= fsdp_pkg::FSDP_CMD_ER_UPR);
   // Erase stays open at every level: it is the only way back from a locked part
   wire erase_go = wr_fctl && is_erase && busy_r;
   wire [12:0] upr_idx = addr16[12:0];

   ////////////////////////////////////////////////////////////////////////
   // Address and data sequencer
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st_r <= FSDP_IDLE;
      end else if (wr_fctl) begin
         st_r <= erase_go ? FSDP_BUSY : FSDP_IDLE;
      end else if (st_r == FSDP_BUSY) begin
         if (busy_cnt_r == 9'h000) begin
            st_r <= FSDP_IDLE;
         end
      end else if (take) begin
         case (st_r)
            FSDP_IDLE:    st_r <= (cmd_r == fsdp_pkg::FSDP_CMD_WR_SEC) ? FSDP_DATA :
                                  ((cmd_r == fsdp_pkg::FSDP_CMD_WR_UPR) ||
                                   (cmd_r == fsdp_pkg::FSDP_CMD_VER_UPR)) ? FSDP_ADDR_LO :
                                  FSDP_IDLE;
            FSDP_ADDR_LO: st_r <= (cmd_r == fsdp_pkg::FSDP_CMD_WR_UPR) ? FSDP_DATA : FSDP_IDLE;
            FSDP_DATA:    st_r <= prog_go ? FSDP_BUSY : FSDP_IDLE;
            default:      st_r <= FSDP_IDLE;
         endcase
      end
   end

   // Address capture: high byte first, low byte second
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         addr_hi_r <= 8'h00;
         addr_lo_r <= 8'h00;
      end else if (take && (st_r == FSDP_IDLE)) begin
         addr_hi_r <= (cmd_r == fsdp_pkg::FSDP_CMD_WR_SEC) ? 8'h00 : i_sfr_wdata;
         addr_lo_r <= i_sfr_wdata;
      end else if (take && (st_r == FSDP_ADDR_LO)) begin
         addr_lo_r <= i_sfr_wdata;
      end
   end

   // Busy counter; busy flag low while an operation runs
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         busy_r     <= 1'b1;
         busy_cnt_r <= 9'h000;
      end else if (prog_go || erase_go) begin
         busy_r     <= 1'b0;
         busy_cnt_r <= 9'(fsdp_pkg::FSDP_PROG_CYCLES - 1);
      end else if (!busy_r) begin
         busy_cnt_r <= busy_cnt_r - 9'h001;
         busy_r     <= (busy_cnt_r == 9'h000);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command field and error flag; error set wins over clear
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         cmd_r <= fsdp_pkg::FSDP_CMD_READ;
         err_r <= 1'b0;
      end else begin
         if (wr_fctl && busy_r) begin
            cmd_r <= i_sfr_wdata[3:0];
         end
         if (new_bad || prog_fail) begin
            err_r <= 1'b1;
         end else if (wr_fctl && (i_sfr_wdata[3:0] == fsdp_pkg::FSDP_CMD_READ)) begin
            err_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data port value: echo writes, return verify data
   always_comb begin
      dport_nxt = dport_r;
      if (wr_fctl && (i_sfr_wdata[3:0] == fsdp_pkg::FSDP_CMD_VER_OPT)) begin
         dport_nxt = o_block_verify ? fsdp_pkg::FSDP_ERASED : opt_r;
      end else if (take) begin
         dport_nxt = i_sfr_wdata;
         if (cmd_r == fsdp_pkg::FSDP_CMD_VER_SEC) begin
            dport_nxt = o_block_verify ? fsdp_pkg::FSDP_ERASED :
                        (i_sfr_wdata <= fsdp_pkg::FSDP_LOCK_ADDR) ?
                        sec_mem[i_sfr_wdata[6:0]] : fsdp_pkg::FSDP_ERASED;
         end else if ((cmd_r == fsdp_pkg::FSDP_CMD_VER_UPR) && (st_r == FSDP_ADDR_LO)) begin
            dport_nxt = o_block_verify ? fsdp_pkg::FSDP_ERASED :
                        upr_mem[{addr_hi_r[4:0], i_sfr_wdata}];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         dport_r <= fsdp_pkg::FSDP_DPORT_RST;
      end else begin
         dport_r <= dport_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flash arrays: not cleared by reset since they model nonvolatile store
   always_ff @(posedge i_clk) begin
      if (prog_go && (cmd_r == fsdp_pkg::FSDP_CMD_WR_UPR)) begin
         upr_mem[upr_idx] <= upr_mem[upr_idx] & i_sfr_wdata;
      end
      if (prog_go && (cmd_r == fsdp_pkg::FSDP_CMD_WR_SEC)) begin
         sec_mem[addr_lo_r[6:0]] <= sec_mem[addr_lo_r[6:0]] & i_sfr_wdata;
      end
      if (take && (cmd_r == fsdp_pkg::FSDP_CMD_WR_OPT) && !o_block_program) begin
         opt_r <= opt_r & i_sfr_wdata;
      end
      if (erase_go && (i_sfr_wdata[3:0] == fsdp_pkg::FSDP_CMD_ER_OPT)) begin
         opt_r <= fsdp_pkg::FSDP_ERASED;
      end
      // Loops sit inside the erase test so idle cycles cost nothing
      if (erase_go && (i_sfr_wdata[3:0] == fsdp_pkg::FSDP_CMD_ER_SEC)) begin
         for (int i = 0; i < fsdp_pkg::FSDP_SEC_DEPTH; i++) begin
            sec_mem[i] <= fsdp_pkg::FSDP_ERASED;
         end
      end
      if (erase_go && (i_sfr_wdata[3:0] == fsdp_pkg::FSDP_CMD_ER_UPR)) begin
         for (int j = 0; j < fsdp_pkg::FSDP_UPR_DEPTH; j++) begin
            upr_mem[j] <= fsdp_pkg::FSDP_ERASED;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog control; protected bits only move under timed access
   wire [7:0] wdc_mask = i_timed_access ? 8'hff : 8'hb4;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         wdc_r[fsdp_pkg::FSDP_WD_BAUD] <= 1'b0;
         wdc_r[fsdp_pkg::FSDP_WD_PFE]  <= 1'b0;
         wdc_r[fsdp_pkg::FSDP_WD_WIF]  <= 1'b0;
         wdc_r[fsdp_pkg::FSDP_WD_RST]  <= 1'b0;
         wdc_r[fsdp_pkg::FSDP_WD_PFF]  <= 1'b0;
         wdc_r[fsdp_pkg::FSDP_WD_WRF]  <= 1'b0;
         wdc_r[fsdp_pkg::FSDP_WD_POR]  <= 1'b0;
         wdc_r[fsdp_pkg::FSDP_WD_EN]   <= 1'b0;
      end else if (i_power_on) begin
         wdc_r[fsdp_pkg::FSDP_WD_POR] <= 1'b1;
         wdc_r[fsdp_pkg::FSDP_WD_EN]  <= !opt_r[fsdp_pkg::FSDP_OPT_WDR_POS];
      end else if (wr_wdc) begin
         wdc_r <= (wdc_r & ~wdc_mask) | (i_sfr_wdata & wdc_mask);
      end
   end
   assign o_watchdog_reset_enable = wdc_r[fsdp_pkg::FSDP_WD_EN];
   assign o_baud_doubling         = wdc_r[fsdp_pkg::FSDP_WD_BAUD];

   ////////////////////////////////////////////////////////////////////////
   // Read mux; control register reserved bits read as one
   assign o_sfr_rdata = (i_sfr_addr == fsdp_pkg::FSDP_ADDR_DPORT) ? dport_r :
                        (i_sfr_addr == fsdp_pkg::FSDP_ADDR_FCTL)  ? {busy_r, err_r, 2'b11, cmd_r} :
                        (i_sfr_addr == fsdp_pkg::FSDP_ADDR_WDC)   ? wdc_r : 8'h00;
endmodule
`default_nettype wire

// ===== fsdp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fsdp_checker (
   // Clock, reset and bus
   input wire logic       i_clk,
   input wire logic       i_resetn,
   input wire logic       i_power_on,
   input wire logic [7:0] i_sfr_addr,
   input wire logic       i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic       i_timed_access,
   input wire logic [7:0] o_sfr_rdata,
   // Gates and watchdog bits
   input wire logic       o_block_ext_code_read,
   input wire logic       o_block_program,
   input wire logic       o_block_verify,
   input wire logic       o_block_ext_data,
   input wire logic       o_block_ext_exec,
   input wire logic       o_watchdog_reset_enable,
   input wire logic       o_baud_doubling
);
   ////////////////////////////////////////////////////////////
   // One domain, so clock and reset are stated once
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // Each level keeps every gate of the level below it
   chk_exec_needs_verify: assert property (o_block_ext_exec |-> o_block_verify)
      else $error("exec gate without verify gate");
   // Pairs are checked both ways as implications so unerased lock bits stay quiet
   chk_verify_data_pair: assert property (o_block_verify |-> o_block_ext_data)
      else $error("verify gate without data gate");
   chk_data_needs_verify: assert property (o_block_ext_data |-> o_block_verify)
      else $error("data gate without verify gate");
   chk_code_prog_pair: assert property (o_block_ext_code_read |-> o_block_program)
      else $error("code read gate without program gate");
   chk_prog_needs_code: assert property (o_block_program |-> o_block_ext_code_read)
      else $error("program gate without code read gate");
   chk_verify_needs_prog: assert property (o_block_verify |-> o_block_program)
      else $error("verify gate without program gate");
   // Readback and pin copy of the watchdog enable must agree
   chk_wdc_en_view: assert property (i_sfr_addr == 8'hd8 |-> o_sfr_rdata[1] == o_watchdog_reset_enable)
      else $error("watchdog enable pin and readback differ");
   // Protected bit ignores a write outside the timed window
   chk_wd_en_protect: assert property (i_sfr_wr && i_sfr_addr == 8'hd8 && !i_timed_access
      && !i_power_on |=> i_power_on || $stable(o_watchdog_reset_enable))
      else $error("watchdog enable changed without timed access");
   chk_baud_write: assert property (i_sfr_wr && i_sfr_addr == 8'hd8 && !i_power_on
      |=> o_baud_doubling == $past(i_sfr_wdata[7]))
      else $error("baud doubling did not take written value");
   // A plain reset leaves both watchdog outputs low
   chk_wdc_reset: assert property ($rose(i_resetn) && !$past(i_power_on)
      |-> !o_watchdog_reset_enable && !o_baud_doubling)
      else $error("watchdog bits not cleared by reset");
endmodule
bind fsdp_flash_security_data_port fsdp_checker u_chk (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_power_on(i_power_on), .i_sfr_addr(i_sfr_addr),
   .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_timed_access(i_timed_access),
   .o_sfr_rdata(o_sfr_rdata), .o_block_ext_code_read(o_block_ext_code_read),
   .o_block_program(o_block_program), .o_block_verify(o_block_verify),
   .o_block_ext_data(o_block_ext_data), .o_block_ext_exec(o_block_ext_exec),
   .o_watchdog_reset_enable(o_watchdog_reset_enable), .o_baud_doubling(o_baud_doubling));
`default_nettype wire

// ===== fsdp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsdp_core_model (
   // Clock and read path
   input  wire logic      i_clk,
   input  wire logic [7:0] i_sfr_rdata,
   // Register bus requests
   output var logic [7:0] o_sfr_addr,
   output var logic       o_sfr_wr,
   output var logic [7:0] o_sfr_wdata,
   output var logic       o_timed_access
);
   ////////////////////////////////////////////////////////////
   // Idle bus from time zero
   initial begin
      o_sfr_addr = 8'hd5;
      o_sfr_wr = 1'b0;
      o_sfr_wdata = 8'h00;
      o_timed_access = 1'b0;
   end
   // One strobe per call, held across exactly one rising edge
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d, input logic t);
      @(negedge i_clk);
      o_sfr_addr = a;
      o_sfr_wdata = d;
      o_sfr_wr = 1'b1;
      o_timed_access = t;
      @(negedge i_clk);
      o_sfr_wr = 1'b0;
      o_timed_access = 1'b0;
      o_sfr_wdata = ~d; // Released data must not look like the last byte
   endtask
   // Readback is combinational, so sample well before the next edge
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clk);
      o_sfr_addr = a;
      #2;
      d = i_sfr_rdata;
   endtask
   // Command first, then address high, address low and the data byte
   task automatic program_upper(input logic [15:0] a, input logic [7:0] d);
      sfr_write(8'hd5, 8'h0b, 1'b1);
      sfr_write(8'hd6, a[15:8], 1'b0);
      sfr_write(8'hd6, a[7:0], 1'b0);
      sfr_write(8'hd6, d, 1'b0);
   endtask
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       clk;
   logic       resetn = 1'b0;
   logic       power_on = 1'b0;
   logic [7:0] addr;
   logic       wr;
   logic [7:0] wdata;
   logic       ta;
   logic [7:0] rdata;
   wire  [4:0] gates;
   logic       wd_en;
   int         mismatches = 0;
   int         checks_done = 0;
   ////////////////////////////////////////////////////////////
   // Core model drives the bus, the block answers
   fsdp_core_model u_fsdp_core_model (.i_clk(clk), .i_sfr_rdata(rdata), .o_sfr_addr(addr),
      .o_sfr_wr(wr), .o_sfr_wdata(wdata), .o_timed_access(ta));
   fsdp_flash_security_data_port u_fsdp_flash_security_data_port (.i_clk(clk),
      .i_resetn(resetn), .i_power_on(power_on), .i_sfr_addr(addr), .i_sfr_wr(wr),
      .i_sfr_wdata(wdata), .i_timed_access(ta), .o_sfr_rdata(rdata),
      .o_block_ext_code_read(gates[4]), .o_block_program(gates[3]),
      .o_block_verify(gates[2]), .o_block_ext_data(gates[1]), .o_block_ext_exec(gates[0]),
      .o_watchdog_reset_enable(wd_en), .o_baud_doubling());
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] m,
                         input logic [7:0] e);
      logic [7:0] v;
      u_fsdp_core_model.sfr_read(a, v);
      chk8(n, e, v & m);
   endtask
   task automatic wr8(input logic [7:0] a, input logic [7:0] d, input logic t);
      u_fsdp_core_model.sfr_write(a, d, t);
   endtask
   // Busy is polled under a bound so a stuck flag cannot hang the run
   task automatic wait_idle();
      logic [7:0] v;
      v = 8'h00;
      for (int i = 0; i < 200 && v[7] !== 1'b1; i++) begin
         u_fsdp_core_model.sfr_read(8'hd5, v);
      end
      chk8("busy_done", 8'h80, v & 8'h80);
   endtask
   // Wipe the security block, then program the lock byte
   task automatic lock_set(input logic [7:0] v);
      wr8(8'hd5, 8'h0d, 1'b1);
      wait_idle();
      wr8(8'hd5, 8'h0a, 1'b1);
      wr8(8'hd6, 8'h40, 1'b0);
      wr8(8'hd6, v, 1'b0);
      wait_idle();
   endtask
   // Power-on is held through the release edge
   task automatic do_reset(input logic p);
      @(negedge clk);
      resetn = 1'b0;
      power_on = p;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      power_on = 1'b0;
   endtask
   // Watchdog cut-off, well beyond the sequence length
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end
   // Main sequence
   initial begin
      do_reset(1'b0);
      rd_chk("dport_reset", 8'hd6, 8'hff, 8'h00);
      rd_chk("wdc_reset", 8'hd8, 8'hff, 8'h00);
      wr8(8'hd6, 8'h33, 1'b0);
      rd_chk("dport_no_cmd", 8'hd6, 8'hff, 8'h00);
      wr8(8'hd5, 8'h05, 1'b1);
      rd_chk("err_bad_cmd", 8'hd5, 8'h40, 8'h40);
      wr8(8'hd6, 8'h33, 1'b0);
      rd_chk("dport_bad_cmd", 8'hd6, 8'hff, 8'h00);
      wr8(8'hd5, 8'h00, 1'b1);
      rd_chk("err_clear", 8'hd5, 8'h40, 8'h00);
      for (int i = 12; i < 15; i++) begin
         wr8(8'hd5, i[7:0], 1'b1);
         wait_idle();
      end
      wr8(8'hd5, 8'h01, 1'b1);
      rd_chk("opt_erased", 8'hd6, 8'hff, 8'hff);
      wr8(8'hd5, 8'h09, 1'b1);
      wr8(8'hd6, 8'h5a, 1'b0);
      wait_idle();
      wr8(8'hd5, 8'h01, 1'b1);
      rd_chk("opt_store", 8'hd6, 8'hff, 8'h5a);
      do_reset(1'b1);
      chk8("wd_en_bit3_one", 8'h00, {7'h00, wd_en});
      wr8(8'hd5, 8'h09, 1'b1);
      wr8(8'hd6, 8'hf7, 1'b0);
      wait_idle();
      do_reset(1'b1);
      rd_chk("wd_en_bit3_zero", 8'hd8, 8'hff, 8'h42);
      wr8(8'hd8, 8'h82, 1'b0);
      rd_chk("wdc_untimed", 8'hd8, 8'hff, 8'hc2);
      wr8(8'hd8, 8'h00, 1'b1);
      rd_chk("wdc_timed", 8'hd8, 8'hff, 8'h00);
      chk8("gates_level1", 8'h00, {3'h0, gates});
      wr8(8'hd5, 8'h02, 1'b1);
      wr8(8'hd6, 8'h40, 1'b0);
      rd_chk("lock_erased", 8'hd6, 8'hff, 8'hff);
      u_fsdp_core_model.program_upper(16'h2010, 8'h5a);
      rd_chk("busy_low", 8'hd5, 8'h80, 8'h00);
      wait_idle();
      wr8(8'hd5, 8'h03, 1'b1);
      wr8(8'hd6, 8'h20, 1'b0);
      wr8(8'hd6, 8'h10, 1'b0);
      rd_chk("upper_byte", 8'hd6, 8'hff, 8'h5a);
      u_fsdp_core_model.program_upper(16'h4000, 8'h11);
      wait_idle();
      rd_chk("err_range", 8'hd5, 8'h40, 8'h40);
      wr8(8'hd5, 8'ha, 1'b1);
      wr8(8'hd6, 8'h40, 1'b0);
      wr8(8'hd6, 8'he7, 1'b0);
      wait_idle();
      chk8("gates_level3", 8'h1e, {3'h0, gates});
      wr8(8'hd5, 8'h02, 1'b1);
      wr8(8'hd6, 8'h40, 1'b0);
      rd_chk("verify_blocked", 8'hd6, 8'hff, 8'hff);
      wr8(8'hd5, 8'h00, 1'b1);
      u_fsdp_core_model.program_upper(16'h2010, 8'h00);
      wait_idle();
      rd_chk("err_locked", 8'hd5, 8'h40, 8'h40);
      // Level 2 by the lowest lock bit alone, then level 4 by the highest alone
      lock_set(8'hf7);
      chk8("gates_level2", 8'h18, {3'h0, gates});
      wr8(8'hd5, 8'h02, 1'b1);
      wr8(8'hd6, 8'h40, 1'b0);
      rd_chk("verify_level2", 8'hd6, 8'hff, 8'hf7);
      wr8(8'hd5, 8'h00, 1'b1);
      u_fsdp_core_model.program_upper(16'h2010, 8'h00);
      rd_chk("err_level2", 8'hd5, 8'h40, 8'h40);
      lock_set(8'hdf);
      chk8("gates_level4", 8'h1f, {3'h0, gates});
      complete_run();
   end
endmodule
`default_nettype wire
